// File: rtl/tbpu_pkg.sv
package tbpu_pkg;
   localparam int unsigned TC_W      = 32;
   localparam int unsigned NUM_MATCH = 7;
   localparam int unsigned NUM_CAP   = 2;
   localparam int unsigned NUM_EMC   = 4;
   localparam int unsigned NUM_PWM   = 6;
   // reset values
   localparam logic [31:0] TC_RST    = 32'h0000_0000;
   localparam logic [31:0] PC_RST    = 32'h0000_0000;
   localparam logic [31:0] MATCH_RST = 32'h0000_0000;
   // count source codes
   localparam logic [1:0]  CNT_TIMER = 2'h0;
   localparam logic [1:0]  CNT_RISE  = 2'h1;
   localparam logic [1:0]  CNT_FALL  = 2'h2;
   localparam logic [1:0]  CNT_BOTH  = 2'h3;
   // external match actions
   localparam logic [1:0]  EMC_NONE  = 2'h0;
   localparam logic [1:0]  EMC_LOW   = 2'h1;
   localparam logic [1:0]  EMC_HIGH  = 2'h2;
   localparam logic [1:0]  EMC_TOGG  = 2'h3;

   // per-match action on a match
   typedef struct packed {
      logic irq;
      logic rst;
      logic stop;
   } tbpu_match_ctl_t;

   // per-capture-input setup
   typedef struct packed {
      logic rise;
      logic fall;
      logic irq;
   } tbpu_cap_ctl_t;
endpackage : tbpu_pkg

// File: rtl/tbpu_match_chan.sv
`timescale 1ns/1ns
module tbpu_match_chan (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic [31:0] value_i,
   input  wire logic        release_i,
   input  wire logic        apply_i,
   input  wire logic [31:0] tc_i,
   input  wire logic        tick_i,
   output logic             match_o,
   output logic [31:0]      eff_o
);
   logic [31:0] staged;
   logic [31:0] shadow;
   logic        pending;

   // value in force from the next cycle on
   assign eff_o   = (apply_i && pending) ? staged : shadow;
   // compare only on a counting tick
   assign match_o = tick_i && (tc_i == shadow);

   // RQ11 RQ14 staging, release and synchronized load
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         staged  <= tbpu_pkg::MATCH_RST;
         shadow  <= tbpu_pkg::MATCH_RST;
         pending <= 1'b0;
      end else begin
         if (release_i) begin
            staged <= value_i;
         end
         shadow  <= eff_o;
         pending <= release_i || (pending && !apply_i); // release beats apply
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   AST_SHADOW_HOLD: assert property ( // RQ11
      !apply_i |=> $stable(shadow))
      else $error("match value changed outside the load point");
   AST_SHADOW_LOAD: assert property ( // RQ14
      (apply_i && pending) |=> (shadow == $past(staged)))
      else $error("released match value not loaded");
endmodule : tbpu_match_chan

// File: rtl/tbpu_core.sv
`timescale 1ns/1ns
// Operation
// RQ1: 32-bit counter behind a 32-bit prescaler, plain timer when PWM is off.
// RQ2: counts clock cycles, or edges of one selected capture input.
// RQ3: seven match registers give six single-edge or three double-edge outputs.
// RQ4: each match may continue, stop or reset the counter, with optional interrupt.
// RQ5: cycle-rate match resets the counter and sets the PWM period.
// RQ6: single-edge output rises at cycle start, falls at its own match.
// RQ7: single-edge output set constant low never rises.
// RQ8: double-edge output rises on one match, falls on the next.
// RQ9: all outputs share the cycle-rate period, each uses its own matches.
// RQ10: period and width settle to any whole number of counts.
// RQ11: software releases new match values; hardware loads them glitch free.
// RQ12: capture input edge copies the counter, optionally raising an interrupt.
// RQ13: timer match outputs may go low, high, toggle or hold.
// RQ14: released match values take effect at the next cycle-rate match.
module tbpu_core (
   input  wire logic                      mclk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      cnt_en_i,
   input  wire logic                      cnt_rst_i,
   input  wire logic                      pwm_mode_i,
   input  wire logic [1:0]                cnt_mode_i,
   input  wire logic                      cnt_src_i,
   input  wire logic [31:0]               prescale_i,
   input  wire logic [6:0][31:0]          match_val_i,
   input  tbpu_pkg::tbpu_match_ctl_t [6:0] match_ctl_i,
   input  wire logic [6:0]                match_release_i,
   input  wire logic [6:1]                pwm_double_i,
   input  wire logic [6:1]                pwm_out_en_i,
   input  wire logic [3:0][1:0]           emc_ctl_i,
   input  wire logic [1:0]                cap_pin_i,
   input  tbpu_pkg::tbpu_cap_ctl_t [1:0]  cap_ctl_i,
   output logic [31:0]                    tc_o,
   output logic [6:1]                     pwm_o,
   output logic [3:0]                     emc_o,
   output logic [1:0][31:0]               cap_val_o,
   output logic [6:0]                     match_evt_o,
   output logic [6:0]                     match_irq_o,
   output logic [1:0]                     cap_irq_o,
   output logic                           halted_o
);
   logic [31:0]      tc;
   logic [31:0]      pc;
   logic             halted;
   logic [1:0]       cap_s1;
   logic [1:0]       cap_s2;
   logic [1:0]       cap_prev;
   logic [1:0]       cap_rise;
   logic [1:0]       cap_fall;
   logic [1:0]       cap_evt;
   logic             src_edge;
   logic             inc_src;
   logic             run;
   logic             tick;
   logic             apply;
   logic [6:0]       match;
   logic [6:0]       m_rst;
   logic [6:0]       m_stop;
   logic [6:0]       m_irq;
   logic [6:0][31:0] eff;
   logic             rst_hit;
   logic             stop_hit;
   logic [6:1]       set_pwm;
   logic [6:1]       clr_pwm;
   logic [6:1]       next_pwm;
   logic [3:0]       next_emc;
   logic [31:0]      next_tc;
   logic [31:0]      next_pc;

   // capture pin synchronisers
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cap_s1   <= 2'h0;
         cap_s2   <= 2'h0;
         cap_prev <= 2'h0;
      end else begin
         cap_s1   <= cap_pin_i;
         cap_s2   <= cap_s1;
         cap_prev <= cap_s2;
      end
   end

   // edge detection on synchronised pins
   assign cap_rise = cap_s2 & ~cap_prev;
   assign cap_fall = ~cap_s2 & cap_prev;
   // RQ2 count source select
   assign src_edge = ((cnt_mode_i == tbpu_pkg::CNT_RISE) && cap_rise[cnt_src_i])
                  || ((cnt_mode_i == tbpu_pkg::CNT_FALL) && cap_fall[cnt_src_i])
                  || ((cnt_mode_i == tbpu_pkg::CNT_BOTH)
                      && (cap_rise[cnt_src_i] || cap_fall[cnt_src_i]));
   assign inc_src  = (cnt_mode_i == tbpu_pkg::CNT_TIMER) || src_edge;
   assign run      = cnt_en_i && !cnt_rst_i && !halted;
   // RQ1 prescaler terminal count
   assign tick     = run && inc_src && (pc == prescale_i);

   // RQ14 load point is the cycle-rate match in PWM mode
   assign apply = pwm_mode_i ? match[0] : 1'b1;

   // RQ3 seven match channels
   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_mch
         tbpu_match_chan u_mch (
            .mclk_i    (mclk_i),
            .rst_n_i   (rst_n_i),
            .value_i   (match_val_i[g]),
            .release_i (match_release_i[g]),
            .apply_i   (apply),
            .tc_i      (tc),
            .tick_i    (tick),
            .match_o   (match[g]),
            .eff_o     (eff[g])
         );
         assign m_rst[g]  = match[g] && match_ctl_i[g].rst;
         assign m_stop[g] = match[g] && match_ctl_i[g].stop;
         assign m_irq[g]  = match[g] && match_ctl_i[g].irq;
      end
   endgenerate

   // RQ5 cycle-rate match always resets in PWM mode
   assign rst_hit  = (|m_rst) || (pwm_mode_i && match[0]);
   assign stop_hit = |m_stop;

   // RQ4 RQ10 next counter values
   assign next_pc = (cnt_rst_i || tick) ? tbpu_pkg::PC_RST
                  : (run && inc_src) ? pc + 32'h0000_0001 : pc;
   assign next_tc = cnt_rst_i ? tbpu_pkg::TC_RST
                  : !tick ? tc
                  : rst_hit ? tbpu_pkg::TC_RST
                  : stop_hit ? tc : tc + 32'h0000_0001;

   // counter, prescaler and stop flag
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tc     <= tbpu_pkg::TC_RST;
         pc     <= tbpu_pkg::PC_RST;
         halted <= 1'b0;
      end else begin
         tc     <= next_tc;
         pc     <= next_pc;
         halted <= stop_hit || (halted && cnt_en_i); // stop wins over re-arm
      end
   end

   // RQ6 RQ7 RQ8 RQ9 per-output set and clear
   generate
      for (g = 1; g < 7; g++) begin : g_pwm
         // constant low also drops a high output at the cycle start
         if (g == 1) begin : g_single_only
            assign set_pwm[g] = match[0] && (eff[g] != 32'h0000_0000);
            assign clr_pwm[g] = match[g] || (match[0] && (eff[g] == 32'h0000_0000));
         end else begin : g_sel
            assign set_pwm[g] = pwm_double_i[g] ? match[g-1]
                              : (match[0] && (eff[g] != 32'h0000_0000));
            assign clr_pwm[g] = pwm_double_i[g] ? match[g]
                              : (match[g] || (match[0] && (eff[g] == 32'h0000_0000)));
         end
         assign next_pwm[g] = (pwm_mode_i && pwm_out_en_i[g])
                            && !clr_pwm[g] && (set_pwm[g] || pwm_o[g]);
      end
   endgenerate

   // RQ13 timer external match actions
   generate
      for (g = 0; g < 4; g++) begin : g_emc
         assign next_emc[g] = !match[g] ? emc_o[g]
            : (emc_ctl_i[g] == tbpu_pkg::EMC_LOW)  ? 1'b0
            : (emc_ctl_i[g] == tbpu_pkg::EMC_HIGH) ? 1'b1
            : (emc_ctl_i[g] == tbpu_pkg::EMC_TOGG) ? !emc_o[g] : emc_o[g];
      end
   endgenerate

   // RQ12 capture events
   assign cap_evt = (cap_rise & {cap_ctl_i[1].rise, cap_ctl_i[0].rise})
                  | (cap_fall & {cap_ctl_i[1].fall, cap_ctl_i[0].fall});

   // registered outputs
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwm_o       <= 6'h00;
         emc_o       <= 4'h0;
         match_evt_o <= 7'h00;
         match_irq_o <= 7'h00;
         tc_o        <= tbpu_pkg::TC_RST;
         halted_o    <= 1'b0;
      end else begin
         pwm_o       <= next_pwm;
         emc_o       <= next_emc;
         match_evt_o <= match;
         match_irq_o <= m_irq;
         tc_o        <= next_tc;
         halted_o    <= stop_hit || (halted && cnt_en_i);
      end
   end

   // capture registers
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cap_val_o <= {2{tbpu_pkg::TC_RST}};
         cap_irq_o <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (cap_evt[i]) begin
               cap_val_o[i] <= tc;
            end
         end
         cap_irq_o <= cap_evt & {cap_ctl_i[1].irq, cap_ctl_i[0].irq};
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_cycle_end;
      pwm_mode_i && match[0];
   endsequence
   sequence s_wrap;
      ##1 (tc == 32'h0000_0000);
   endsequence

   AST_PRESCALE: assert property ( // RQ1
      (run && inc_src && pc != prescale_i) |=> ($stable(tc) && pc == $past(pc) + 32'h1))
      else $error("counter moved before prescaler terminal count");
   AST_COUNT_INC: assert property ( // RQ10
      (tick && !rst_hit && !stop_hit && !cnt_rst_i) |=> (tc == $past(tc) + 32'h1))
      else $error("counter did not step by one");
   AST_EDGE_SRC: assert property ( // RQ2
      (tick && cnt_mode_i != tbpu_pkg::CNT_TIMER) |-> src_edge)
      else $error("counter ticked without a source edge");
   AST_PERIOD_RESET: assert property ( // RQ5
      (s_cycle_end and !cnt_rst_i) |-> s_wrap)
      else $error("cycle-rate match did not restart the counter");
   AST_STOP: assert property ( // RQ4
      (stop_hit && !rst_hit && !cnt_rst_i) |=> (halted && $stable(tc)) ##1 halted_o)
      else $error("stop on match did not hold the counter");
   AST_MATCH_IRQ: assert property ( // RQ4
      (match[0] && match_ctl_i[0].irq) |=> match_irq_o[0])
      else $error("match interrupt missing");
   AST_SINGLE_RISE: assert property ( // RQ6
      (s_cycle_end and (pwm_out_en_i[1] && eff[1] != 32'h0)) |=> pwm_o[1])
      else $error("single-edge output failed to rise at cycle start");
   AST_CONST_LOW: assert property ( // RQ7
      (s_cycle_end and (!pwm_double_i[2] && eff[2] == 32'h0)) |=> !pwm_o[2])
      else $error("constant-low output rose");
   AST_DOUBLE_FALL: assert property ( // RQ8
      (pwm_mode_i && pwm_double_i[4] && match[4]) |=> !pwm_o[4])
      else $error("double-edge output missed its falling edge");
   AST_EMC_TOGGLE: assert property ( // RQ13
      (match[1] && emc_ctl_i[1] == tbpu_pkg::EMC_TOGG) |=> (emc_o[1] != $past(emc_o[1])))
      else $error("external match output failed to toggle");
   AST_CAPTURE: assert property ( // RQ12
      cap_evt[0] |=> (cap_val_o[0] == $past(tc)))
      else $error("capture register missed the counter value");
endmodule : tbpu_core

// File: dv/tbpu_load.sv
`timescale 1ns/1ns
module tbpu_load (
   input  wire logic       mclk_i,
   input  wire logic       clr_i,
   input  wire logic [6:1] pwm_i,
   output int              hi_o [1:6],
   output int              rise_o
);
   logic prev;
   // on-time of every line, pulse count of line one
   always @(posedge mclk_i) begin
      prev <= pwm_i[1];
      for (int k = 1; k <= 6; k++) begin
         hi_o[k] <= clr_i ? 0 : hi_o[k] + int'(pwm_i[k] === 1'b1);
      end
      rise_o <= clr_i ? 0 : rise_o + int'(pwm_i[1] === 1'b1 && prev === 1'b0);
   end
endmodule : tbpu_load

// File: dv/timer_based_pwm_unit_bench.sv
`timescale 1ns/1ns
module timer_based_pwm_unit_bench;
   logic mclk = 0, rst_n = 0, en = 0, crst = 0, pmode = 0, src = 0, clr = 0, e;
   logic [1:0]                     mode = 0, cap = 0, cirq;
   logic [31:0]                    pre = 0, tc, t;
   logic [6:0][31:0]               mval = '0;
   tbpu_pkg::tbpu_match_ctl_t [6:0] mctl = '0;
   tbpu_pkg::tbpu_cap_ctl_t [1:0]  cctl = '0;
   logic [6:0]                     rel = 0, mevt, mirq;
   logic [6:1]                     dbl = 0, oen = 0, pwm;
   logic [3:0][1:0]                ectl = '0;
   logic [3:0]                     emc;
   logic [1:0][31:0]               capv;
   logic                           halted;
   logic [1:0]                     codes [5];
   int                             hi [1:6], rise, n, num_errors = 0, num_checks = 0;
   int                             hon [1:6] = '{4, 0, 8, 8, 3, 4};
   tbpu_core tbpu_core_i (.mclk_i(mclk), .rst_n_i(rst_n), .cnt_en_i(en), .cnt_rst_i(crst),
      .pwm_mode_i(pmode), .cnt_mode_i(mode), .cnt_src_i(src), .prescale_i(pre),
      .match_val_i(mval), .match_ctl_i(mctl), .match_release_i(rel), .pwm_double_i(dbl),
      .pwm_out_en_i(oen), .emc_ctl_i(ectl), .cap_pin_i(cap), .cap_ctl_i(cctl), .tc_o(tc),
      .pwm_o(pwm), .emc_o(emc), .cap_val_o(capv), .match_evt_o(mevt), .match_irq_o(mirq),
      .cap_irq_o(cirq), .halted_o(halted));
   tbpu_load tbpu_load_i (.mclk_i(mclk), .clr_i(clr), .pwm_i(pwm), .hi_o(hi), .rise_o(rise));
   // free running clock
   initial forever #10 mclk = ~mclk;
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask : cyc
   // a loop that used up its bound ends the run as a failure
   task automatic limit(input int lim);
      if (n >= lim) begin
         num_errors++;
         stop_test();
      end
   endtask : limit
   // bounded waits on the count or on a match pulse
   task automatic wait_on(input bit evt, input logic [31:0] v);
      for (n = 0; n < 2000 && (evt ? mevt[v] !== 1'b1 : tc !== v); n++) cyc(1);
      limit(2000);
   endtask : wait_on
   task automatic set_m(input int k, input logic [31:0] v);
      mval[k] = v;
      rel[k] = 1'b1;
      cyc(1);
      rel[k] = 1'b0;
   endtask : set_m
   initial begin
      codes = '{tbpu_pkg::EMC_HIGH, tbpu_pkg::EMC_TOGG, tbpu_pkg::EMC_NONE,
                tbpu_pkg::EMC_TOGG, tbpu_pkg::EMC_LOW};
      cyc(6);
      rst_n = 1;
      cyc(1);
      pre = 32'h2;
      en = 1;
      wait_on(0, 1);
      for (n = 0; tc === 32'h1 && n < 20; n++) cyc(1);
      limit(20);
      check("prescale", n, 3);
      pre = 0;
      mode = tbpu_pkg::CNT_RISE;
      src = 1;
      crst = 1;
      cyc(1);
      crst = 0;
      repeat (5) begin
         cap[1] = 1;
         cyc(4);
         cap[1] = 0;
         cyc(4);
      end
      check("edge count", tc, 5);
      en = 0;
      cctl[0] = '{rise: 1'b1, fall: 1'b0, irq: 1'b1};
      cap[0] = 1;
      for (n = 0; cirq[0] !== 1'b1 && n < 20; n++) cyc(1);
      limit(20);
      check("capture", capv[0], 5);
      mode = tbpu_pkg::CNT_TIMER;
      mctl[0] = '{irq: 1'b1, rst: 1'b1, stop: 1'b0};
      ectl[1] = tbpu_pkg::EMC_TOGG;
      // count from zero so the first match is not skipped
      crst = 1;
      set_m(0, 4);
      crst = 0;
      en = 1;
      e = 0;
      for (int k = 0; k < 5; k++) begin
         ectl[0] = codes[k];
         wait_on(1, 0);
         cyc(1);
         e = codes[k] == tbpu_pkg::EMC_TOGG ? ~e : codes[k] == tbpu_pkg::EMC_NONE ? e :
             codes[k] == tbpu_pkg::EMC_HIGH;
         check("match out", emc[0], e);
      end
      for (n = 1; mirq[0] !== 1'b1 && n < 20; n++) cyc(1);
      limit(20);
      check("reset period", n, 5);
      check("no pwm", pwm, 0);
      mctl[0] = '{irq: 1'b0, rst: 1'b0, stop: 1'b1};
      cyc(7);
      t = tc;
      cyc(5);
      check("halted", halted, 1);
      check("held", tc, t);
      en = 0;
      mctl[0] = '0;
      pmode = 1;
      oen = '1;
      dbl = 6'h28;
      crst = 1;
      cyc(1);
      crst = 0;
      en = 1;
      set_m(0, 9);
      set_m(1, 3);
      set_m(2, 0);
      set_m(3, 7);
      set_m(4, 5);
      set_m(5, 2);
      set_m(6, 6);
      wait_on(1, 0);
      cyc(1);
      wait_on(1, 0);
      clr = 1;
      cyc(1);
      clr = 0;
      cyc(20);
      for (int k = 1; k <= 6; k++) check("on time", hi[k], 2 * hon[k]);
      check("period", rise, 2);
      mval[1] = 6;
      wait_on(1, 0);
      wait_on(0, 5);
      check("unreleased", pwm[1], 0);
      wait_on(0, 1);
      set_m(1, 6);
      wait_on(0, 5);
      check("mid period", pwm[1], 0);
      cyc(1);
      wait_on(0, 5);
      check("next period", pwm[1], 1);
      stop_test();
   end
endmodule : timer_based_pwm_unit_bench
